// *** core/hlc_loop_ctrl.sv ***
// hlc_loop_ctrl: zero-overhead hardware loop controller with wishbone status access
//
// Function
// RL1: first cycle pushes end address and counter
// RL2: endless setup keeps live counter unchanged
// RL3: second cycle pushes body start and status
// RL4: endless end address from absolute extension word
// RL5: third cycle sets loop and endless flags
// RL6: end match copies stack top into fetch
// RL7: endless match decrements counter, never tested
// RL8: endless loop leaves only by abort/break
// RL9: interrupts stay allowed while loops run
// RL10: nested loop ends strictly nested, never equal
// RL11: software encodes loop end as next minus one
// RL12: condition code byte never changed here; a wishbone write to the status offset still updates it
// RL13: relative end address is pc plus displacement
// RL14: counter loaded from selected operand source
// RL15: zero count: skip, or 65536 with compat
// RL16: short immediate zero-extended into counter
// RL17: immediate from twelve bits, abs 0-63
// RL18: stack top high word refused as source
// RL19: long displacement mode refused for memory count
// RL20: counted loop pushes two stack entries
// RL21: stack pointer source loads pointer plus one
// RL22: no flow or stack writes near loop end
// RL23: counted match: decrement, or fall through at one
`timescale 1ns/1ps
module hlc_loop_ctrl #(
  parameter int STACK_DEPTH = 16
) (
  input  wire logic                         clock,
  input  wire logic                         srst,
  // wishbone slave
  input  wire logic                         wbCyc,
  input  wire logic                         wbStb,
  input  wire logic                         wbWe,
  input  wire logic [hlc_pkg::WB_AW-1:0]    wbAdr,
  input  wire logic [3:0]                   wbSel,
  input  wire logic [hlc_pkg::WB_DW-1:0]    wbDatI,
  output logic      [hlc_pkg::WB_DW-1:0]    wbDatO,
  output logic                              wbAck,
  // loop instruction from decode
  input  wire hlc_pkg::hlc_loop_req_t       loopReq,
  output logic                              loopReady,
  output logic                              loopReject,
  output logic      [hlc_pkg::ABS_W-1:0]    countAddr,
  // loop exit instructions
  input  wire logic                         loopAbort,
  input  wire logic                         loopBreak,
  // fetch side
  input  wire logic                         fetchValid,
  input  wire logic [hlc_pkg::ADDR_W-1:0]   fetchAddr,
  output hlc_pkg::hlc_redirect_t            redirect,
  // status toward the core
  output logic      [hlc_pkg::WORD_W-1:0]   statusWord,
  output logic                              irqAllowed,
  output logic                              stackErr
);

  localparam int PW = $clog2(STACK_DEPTH) + 1;

  initial begin
    if (STACK_DEPTH < 4) begin
      $error("hlc_loop_ctrl: STACK_DEPTH must hold at least two loop contexts");
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state and registers

  hlc_pkg::hlc_state_t               state_q;
  hlc_pkg::hlc_state_t               state_d;
  hlc_pkg::hlc_loop_req_t            req_q;
  logic [hlc_pkg::ADDR_W-1:0]        la_q;
  logic [hlc_pkg::ADDR_W-1:0]        la_d;
  logic [hlc_pkg::WORD_W-1:0]        lc_q;
  logic [hlc_pkg::WORD_W-1:0]        lc_d;
  logic                              lf_q;
  logic                              lf_d;
  logic                              fv_q;
  logic                              fv_d;
  logic [hlc_pkg::WORD_W-1:0]        sr_q;
  logic                              reject_q;
  logic                              redirValid_q;
  logic [hlc_pkg::ADDR_W-1:0]        redirAddr_q;
  logic                              redirValid_d;
  logic [hlc_pkg::ADDR_W-1:0]        redirAddr_d;
  logic [hlc_pkg::ABS_W-1:0]         countAddr_q;
  logic                              ack_q;
  logic [hlc_pkg::WB_DW-1:0]         rdata_q;

  logic                              stkPush;
  logic                              stkPop;
  logic [hlc_pkg::WORD_W-1:0]        stkPushHi;
  logic [hlc_pkg::WORD_W-1:0]        stkPushLo;
  logic [hlc_pkg::WORD_W-1:0]        stkTopHi;
  logic [hlc_pkg::WORD_W-1:0]        stkTopLo;
  logic [PW-1:0]                     stkDepth;

  //////////////////////////////////////////////////////////////////////////////
  // system stack

  hlc_sys_stack #(
    .DEPTH (STACK_DEPTH),
    .W     (hlc_pkg::WORD_W)
  ) u_stack (
    .clock    (clock),
    .srst     (srst),
    .push     (stkPush),
    .pop      (stkPop),
    .pushHi   (stkPushHi),
    .pushLo   (stkPushLo),
    .topHi    (stkTopHi),
    .topLo    (stkTopLo),
    .depth    (stkDepth),
    .stackErr (stackErr)
  );

  //////////////////////////////////////////////////////////////////////////////
  // decode of status, request legality and count value

  // loop flags merged over the software-held status bits, ccr bits pass untouched
  wire logic [hlc_pkg::WORD_W-1:0] srMerged = { // RL12
    sr_q[hlc_pkg::WORD_W-1:hlc_pkg::SR_LF_BIT+1],
    lf_q,
    fv_q,
    sr_q[hlc_pkg::SR_FV_BIT-1:0]
  };
  wire logic scMode   = sr_q[hlc_pkg::SR_SC_BIT];
  wire logic idle     = (state_q == hlc_pkg::ST_IDLE);
  wire logic counted  = (req_q.kind == hlc_pkg::KIND_COUNTED);

  wire logic badReg   = (loopReq.src == hlc_pkg::SRC_REG) &&
                        (loopReq.regSel == hlc_pkg::REG_CODE_SSH); // RL18
  wire logic badEa    = (loopReq.src == hlc_pkg::SRC_EA) &&
                        (loopReq.eaMode == hlc_pkg::EA_MODE_LONG_DISP); // RL19
  wire logic reqIllegal = (loopReq.kind == hlc_pkg::KIND_COUNTED) && (badReg || badEa);

  // immediate count built from the split twelve-bit field, zero-extended
  wire logic [hlc_pkg::WORD_W-1:0] immCount = { // RL16
    {(hlc_pkg::WORD_W-hlc_pkg::IMM_HI_W-hlc_pkg::IMM_LO_W){1'b0}},
    req_q.immHi,
    req_q.immLo
  }; // RL17
  wire logic [hlc_pkg::WORD_W-1:0] spCount =
    hlc_pkg::WORD_W'(stkDepth) + hlc_pkg::LC_ONE; // RL21
  wire logic [hlc_pkg::WORD_W-1:0] rawCount =
    (req_q.src == hlc_pkg::SRC_IMM) ? immCount :
    (req_q.src == hlc_pkg::SRC_SP)  ? spCount  :
                                      req_q.countData; // RL14
  wire logic [hlc_pkg::WORD_W-1:0] loadCount =
    ((rawCount == hlc_pkg::LC_ZERO) && scMode) ? hlc_pkg::LC_SC_ZERO : rawCount; // RL15

  wire logic [hlc_pkg::ADDR_W-1:0] endAddr =
    counted ? (req_q.nextPc + req_q.extWord) : req_q.extWord; // RL4 RL13

  // loop-running events, looked at only while no setup or unwind is in flight
  wire logic exitReq  = idle && lf_q && (loopAbort || loopBreak); // RL8
  wire logic endMatch = idle && lf_q && fetchValid && (fetchAddr == la_q);
  wire logic lcAboveOne = (lc_q > hlc_pkg::LC_ONE);

  assign loopReady = idle && !exitReq && !endMatch;
  wire logic reqTake = loopReq.valid && loopReady;

  //////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    state_d      = state_q;
    la_d         = la_q;
    lc_d         = lc_q;
    lf_d         = lf_q;
    fv_d         = fv_q;
    stkPush      = 1'b0;
    stkPop       = 1'b0;
    stkPushHi    = la_q;
    stkPushLo    = lc_q;
    redirValid_d = 1'b0;
    redirAddr_d  = redirAddr_q;
    case (state_q)
      hlc_pkg::ST_IDLE: begin
        if (exitReq) begin
          if (loopBreak) begin
            redirValid_d = 1'b1;
            redirAddr_d  = la_q + hlc_pkg::ADDR_ONE;
          end
          state_d = hlc_pkg::ST_POP1; // RL8
        end else if (endMatch) begin
          if (fv_q || lcAboveOne) begin
            redirValid_d = 1'b1;
            redirAddr_d  = stkTopHi; // RL6
            lc_d         = lc_q - hlc_pkg::LC_ONE; // RL7 RL23
          end else begin
            state_d = hlc_pkg::ST_POP1; // RL23
          end
        end else if (reqTake && !reqIllegal) begin
          state_d = hlc_pkg::ST_PUSH1;
        end
      end
      hlc_pkg::ST_PUSH1: begin
        stkPush   = 1'b1; // RL1 RL20
        stkPushHi = la_q;
        stkPushLo = lc_q;
        if (counted) begin
          lc_d = loadCount; // RL14
        end // RL2
        state_d = hlc_pkg::ST_PUSH2;
      end
      hlc_pkg::ST_PUSH2: begin
        stkPush   = 1'b1; // RL3 RL20
        stkPushHi = req_q.nextPc;
        stkPushLo = srMerged;
        la_d      = endAddr; // RL4 RL13
        state_d   = hlc_pkg::ST_ARM;
      end
      hlc_pkg::ST_ARM: begin
        if (counted && (lc_q == hlc_pkg::LC_ZERO)) begin
          redirValid_d = 1'b1;
          redirAddr_d  = la_q + hlc_pkg::ADDR_ONE; // RL15
          state_d      = hlc_pkg::ST_POP1;
        end else begin
          lf_d    = 1'b1; // RL5
          fv_d    = !counted; // RL5
          state_d = hlc_pkg::ST_IDLE;
        end
      end
      hlc_pkg::ST_POP1: begin
        stkPop  = 1'b1;
        lf_d    = stkTopLo[hlc_pkg::SR_LF_BIT];
        fv_d    = stkTopLo[hlc_pkg::SR_FV_BIT];
        state_d = hlc_pkg::ST_POP2;
      end
      hlc_pkg::ST_POP2: begin
        stkPop  = 1'b1;
        la_d    = stkTopHi;
        lc_d    = stkTopLo;
        state_d = hlc_pkg::ST_IDLE;
      end
      default: begin
        state_d = hlc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q      <= hlc_pkg::ST_IDLE;
      la_q         <= '0;
      lc_q         <= '0;
      lf_q         <= 1'b0;
      fv_q         <= 1'b0;
      redirValid_q <= 1'b0;
      redirAddr_q  <= '0;
    end else begin
      state_q      <= state_d;
      la_q         <= la_d;
      lc_q         <= lc_d;
      lf_q         <= lf_d;
      fv_q         <= fv_d;
      redirValid_q <= redirValid_d;
      redirAddr_q  <= redirAddr_d;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      req_q       <= '0;
      reject_q    <= 1'b0;
      countAddr_q <= '0;
    end else begin
      reject_q <= reqTake && reqIllegal; // RL18 RL19
      if (reqTake && !reqIllegal) begin
        req_q       <= loopReq;
        countAddr_q <= loopReq.absAddr; // RL17
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave

  wire logic                       busReq   = wbCyc && wbStb;
  wire logic                       wrStatus = busReq && wbWe && ack_q &&
                                              (wbAdr == hlc_pkg::OFS_STATUS);
  wire logic [hlc_pkg::WORD_W-1:0] laneMask;
  wire logic [hlc_pkg::WORD_W-1:0] srWrite;

  genvar gl;
  generate
    for (gl = 0; gl < hlc_pkg::WORD_W / 8; gl++) begin : g_lane
      assign laneMask[gl*8 +: 8] = {8{wbSel[gl]}};
    end
  endgenerate

  assign srWrite = (sr_q & ~laneMask) | (wbDatI[hlc_pkg::WORD_W-1:0] & laneMask);

  wire logic [hlc_pkg::WB_DW-1:0] rdMux =
    (wbAdr == hlc_pkg::OFS_STATUS) ? hlc_pkg::WB_DW'(srMerged) :
    (wbAdr == hlc_pkg::OFS_LA)     ? hlc_pkg::WB_DW'(la_q)     :
    (wbAdr == hlc_pkg::OFS_LC)     ? hlc_pkg::WB_DW'(lc_q)     :
    (wbAdr == hlc_pkg::OFS_SP)     ? hlc_pkg::WB_DW'(stkDepth) :
                                     '0;

  always_ff @(posedge clock) begin
    if (srst) begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
      sr_q    <= hlc_pkg::SR_RESET;
    end else begin
      ack_q <= busReq && !ack_q;
      if (busReq && !ack_q) begin
        rdata_q <= rdMux;
      end
      if (wrStatus) begin
        sr_q <= srWrite;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign wbAck          = ack_q;
  assign wbDatO         = rdata_q;
  assign loopReject     = reject_q;
  assign countAddr      = countAddr_q;
  assign redirect.valid = redirValid_q;
  assign redirect.addr  = redirAddr_q;
  assign statusWord     = srMerged;
  assign irqAllowed     = idle; // RL9

endmodule : hlc_loop_ctrl

// *** pkg/hlc_pkg.sv ***
// hlc_pkg: shared constants, encodings and carriers for the hardware loop controller
package hlc_pkg;

  localparam int ADDR_W = 24;
  localparam int WORD_W = 24;
  localparam int WB_DW  = 32;
  localparam int WB_AW  = 8;

  // status word layout
  localparam int SR_SC_BIT  = 13;
  localparam int SR_FV_BIT  = 14;
  localparam int SR_LF_BIT  = 15;
  localparam int CCR_W      = 8;
  localparam logic [WORD_W-1:0] SR_RESET = 24'h000000;

  // count handling
  localparam int IMM_HI_W = 4;
  localparam int IMM_LO_W = 8;
  localparam int ABS_W    = 6;
  localparam int REG_W    = 6;
  localparam int EA_MODE_W = 3;
  localparam logic [WORD_W-1:0] LC_ONE        = 24'h000001;
  localparam logic [WORD_W-1:0] LC_ZERO       = 24'h000000;
  localparam logic [WORD_W-1:0] LC_SC_ZERO    = 24'h010000;
  localparam logic [ADDR_W-1:0] ADDR_ONE      = 24'h000001;
  localparam logic [REG_W-1:0]  REG_CODE_SSH  = 6'h3C;
  localparam logic [EA_MODE_W-1:0] EA_MODE_LONG_DISP = 3'h7;

  // register map (byte offsets)
  localparam logic [WB_AW-1:0] OFS_STATUS = 8'h00;
  localparam logic [WB_AW-1:0] OFS_LA     = 8'h04;
  localparam logic [WB_AW-1:0] OFS_LC     = 8'h08;
  localparam logic [WB_AW-1:0] OFS_SP     = 8'h0C;

  typedef enum logic [0:0] {
    KIND_FOREVER = 1'h0,
    KIND_COUNTED = 1'h1
  } hlc_kind_t;

  typedef enum logic [2:0] {
    SRC_EA  = 3'h0,
    SRC_ABS = 3'h1,
    SRC_IMM = 3'h2,
    SRC_REG = 3'h3,
    SRC_SP  = 3'h4
  } hlc_src_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_PUSH1 = 3'h1,
    ST_PUSH2 = 3'h3,
    ST_ARM   = 3'h2,
    ST_POP1  = 3'h6,
    ST_POP2  = 3'h7
  } hlc_state_t;

  typedef struct packed {
    logic                  valid;
    hlc_kind_t             kind;
    hlc_src_t              src;
    logic [IMM_HI_W-1:0]   immHi;
    logic [IMM_LO_W-1:0]   immLo;
    logic [ABS_W-1:0]      absAddr;
    logic [REG_W-1:0]      regSel;
    logic [EA_MODE_W-1:0]  eaMode;
    logic [WORD_W-1:0]     extWord;
    logic [ADDR_W-1:0]     nextPc;
    logic [WORD_W-1:0]     countData;
  } hlc_loop_req_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } hlc_redirect_t;

endpackage : hlc_pkg

// *** core/hlc_sys_stack.sv ***
// hlc_sys_stack: two-word system stack with depth pointer
`timescale 1ns/1ps
module hlc_sys_stack #(
  parameter int DEPTH = 16,
  parameter int W     = 24
) (
  input  wire logic                   clock,
  input  wire logic                   srst,
  input  wire logic                   push,
  input  wire logic                   pop,
  input  wire logic [W-1:0]           pushHi,
  input  wire logic [W-1:0]           pushLo,
  output logic      [W-1:0]           topHi,
  output logic      [W-1:0]           topLo,
  output logic      [$clog2(DEPTH):0] depth,
  output logic                        stackErr
);

  localparam int PW = $clog2(DEPTH) + 1;
  localparam logic [PW-1:0] P_ONE  = PW'(1);
  localparam logic [PW-1:0] P_FULL = PW'(DEPTH);

  initial begin
    if (DEPTH < 2) begin
      $error("hlc_sys_stack: DEPTH must be at least 2");
    end
  end

  logic [W-1:0]  hiMem [DEPTH];
  logic [W-1:0]  loMem [DEPTH];
  logic [PW-1:0] sp_q;
  logic          err_q;

  wire logic          doPush = push && (sp_q != P_FULL);
  wire logic          doPop  = pop && !push && (sp_q != '0);
  wire logic [PW-1:0] topIdx = sp_q - P_ONE;

  always_ff @(posedge clock) begin
    if (srst) begin
      sp_q  <= '0;
      err_q <= 1'b0;
    end else begin
      err_q <= (push && (sp_q == P_FULL)) || (pop && !push && (sp_q == '0));
      if (doPush) begin
        sp_q <= sp_q + P_ONE;
      end else if (doPop) begin
        sp_q <= topIdx;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (doPush) begin
      hiMem[sp_q[PW-2:0]] <= pushHi;
      loMem[sp_q[PW-2:0]] <= pushLo;
    end
  end

  assign topHi    = (sp_q == '0) ? '0 : hiMem[topIdx[PW-2:0]];
  assign topLo    = (sp_q == '0) ? '0 : loMem[topIdx[PW-2:0]];
  assign depth    = sp_q;
  assign stackErr = err_q;

endmodule : hlc_sys_stack

// *** verification/hlc_loop_chk.sv ***
// hlc_loop_chk: port assertions for the loop controller
`timescale 1ns/1ps
module hlc_loop_chk (
  input wire logic                   clock,
  input wire logic                   srst,
  input wire logic                   wbAck,
  input wire hlc_pkg::hlc_loop_req_t loopReq,
  input wire logic                   loopReady,
  input wire logic                   loopReject,
  input wire logic [5:0]             countAddr,
  input wire logic                   loopAbort,
  input wire logic                   loopBreak,
  input wire logic                   fetchValid,
  input wire logic [23:0]            fetchAddr,
  input wire hlc_pkg::hlc_redirect_t redirect,
  input wire logic [23:0]            statusWord,
  input wire logic                   irqAllowed
);
  wire logic take   = loopReq.valid && loopReady;
  wire logic cnt    = loopReq.kind == hlc_pkg::KIND_COUNTED;
  wire logic regBad = cnt && loopReq.src == hlc_pkg::SRC_REG && loopReq.regSel == 6'h3C;
  wire logic eaBad  = cnt && loopReq.src == hlc_pkg::SRC_EA && loopReq.eaMode == 3'h7;
  wire logic good   = take && !regBad && !eaBad;
  wire logic fvTake = good && !cnt;
  wire logic zero   = cnt && loopReq.src == hlc_pkg::SRC_IMM && loopReq.immHi == 4'h0
                      && loopReq.immLo == 8'h00 && !statusWord[13];
  logic [23:0] endQ;
  logic [23:0] bodyQ;
  always_ff @(posedge clock) begin
    if (fvTake) begin
      endQ  <= loopReq.extWord;
      bodyQ <= loopReq.nextPc;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////
  setup_busy_a: assert property (good |=> !loopReady [*3])
    else $error("ready high during loop setup");
  reg_reject_a: assert property (take && regBad |=> loopReject)
    else $error("stack top source not refused");
  ea_reject_a: assert property (take && eaBad |=> loopReject)
    else $error("long displacement not refused");
  flags_set_a: assert property (fvTake |-> ##[3:5] (statusWord[15] && statusWord[14]))
    else $error("loop flags not set");
  loop_back_a: assert property (irqAllowed && statusWord[14] && fetchValid
    && fetchAddr == endQ && !loopAbort && !loopBreak |=> redirect.valid && redirect.addr == bodyQ)
    else $error("no return to body start");
  irq_open_a: assert property (statusWord[15] && loopReady |-> irqAllowed)
    else $error("interrupts blocked in loop");
  ccr_kept_a: assert property (!$past(wbAck) |-> $stable(statusWord[7:0]))
    else $error("condition codes changed");
  zero_skip_a: assert property (good && zero |-> ##[3:5] redirect.valid)
    else $error("zero count not skipped");
  count_addr_a: assert property (good |=> countAddr == $past(loopReq.absAddr))
    else $error("short address not kept");
  cover property (fvTake);
  cover property (good && cnt);
  cover property (loopReject);
endmodule : hlc_loop_chk
bind hlc_loop_ctrl hlc_loop_chk chk (.clock(clock), .srst(srst), .wbAck(wbAck),
  .loopReq(loopReq), .loopReady(loopReady), .loopReject(loopReject), .countAddr(countAddr),
  .loopAbort(loopAbort), .loopBreak(loopBreak), .fetchValid(fetchValid),
  .fetchAddr(fetchAddr), .redirect(redirect), .statusWord(statusWord),
  .irqAllowed(irqAllowed));

// *** verification/hlc_core_model.sv ***
// hlc_core_model: fetch stream of the core facing the loop controller
`timescale 1ns/1ps
module hlc_core_model (
  input  wire logic                   clock,
  input  wire logic                   srst,
  input  wire logic                   run,
  input  wire logic                   slow,
  input  wire logic [23:0]            startAddr,
  input  wire hlc_pkg::hlc_redirect_t redirect,
  output logic                        fetchValid,
  output logic [23:0]                 fetchAddr
);
  logic        runQ;
  logic        validQ;
  logic [23:0] pcQ;
  // idle fetch bus shows the inverse address, never a stale one
  assign fetchValid = validQ;
  assign fetchAddr  = validQ ? pcQ : ~pcQ;
  always_ff @(posedge clock) begin
    runQ <= run && !srst;
    if (srst || !run) begin
      validQ <= 1'b0;
      pcQ    <= srst ? 24'h000000 : pcQ;
    end else if (!runQ) begin
      validQ <= 1'b1;
      pcQ    <= startAddr;
    end else if (redirect.valid) begin
      validQ <= 1'b1;
      pcQ    <= redirect.addr;
    end else begin
      validQ <= !(slow && validQ);
      pcQ    <= pcQ + {23'h000000, validQ};
    end
  end
endmodule : hlc_core_model

// *** verification/tb.sv ***
// tb: self-checking bench for the hardware loop controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb;
  localparam logic [7:0] aStat = hlc_pkg::OFS_STATUS;
  localparam logic [7:0] aEnd = hlc_pkg::OFS_LA;
  localparam logic [7:0] aCnt = hlc_pkg::OFS_LC;
  localparam logic [7:0] aDep = hlc_pkg::OFS_SP;
  logic                   clock, srst, wbCyc, wbStb, wbWe, wbAck, loopReady, loopReject;
  logic                   loopAbort, loopBreak, fetchValid, irqAllowed, stackErr, run, slow;
  logic [3:0]             wbSel;
  logic [7:0]             wbAdr;
  logic [5:0]             countAddr;
  logic [31:0]            wbDatI, wbDatO, rd, v;
  logic [23:0]            fetchAddr, statusWord, startAddr, lastRedir;
  hlc_pkg::hlc_loop_req_t req;
  hlc_pkg::hlc_redirect_t redirect;
  int                     n_mismatch, comparisons, seed, nRedir, nReject, r0, lcM, body, la, n;
  int                     nErr;
  int                     savedLc[$];
  hlc_loop_ctrl #(.STACK_DEPTH(16)) uut (.clock(clock), .srst(srst), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI),
    .wbDatO(wbDatO), .wbAck(wbAck), .loopReq(req), .loopReady(loopReady),
    .loopReject(loopReject), .countAddr(countAddr), .loopAbort(loopAbort),
    .loopBreak(loopBreak), .fetchValid(fetchValid), .fetchAddr(fetchAddr),
    .redirect(redirect), .statusWord(statusWord), .irqAllowed(irqAllowed),
    .stackErr(stackErr));
  hlc_core_model partner (.clock(clock), .srst(srst), .run(run), .slow(slow),
    .startAddr(startAddr), .redirect(redirect), .fetchValid(fetchValid),
    .fetchAddr(fetchAddr));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    if (redirect.valid === 1'b1) begin
      nRedir <= nRedir + 1;
      lastRedir <= redirect.addr;
    end
    if (loopReject === 1'b1) nReject <= nReject + 1;
    if (stackErr !== 1'b0 && srst === 1'b0) nErr <= nErr + 1;
  end
  ////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic waitReady();
    int k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (loopReady !== 1'b1 && k < 30);
    if (k >= 30) begin
      n_mismatch++;
      complete_run();
    end
  endtask : waitReady
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clock);
    {wbCyc, wbStb, wbWe, wbSel, wbAdr, wbDatI} <= {2'b11, we, 4'hF, a, d};
    do begin
      @(posedge clock);
      k++;
    end while (wbAck !== 1'b1 && k < 30);
    rd = wbDatO;
    {wbCyc, wbStb} <= 2'b00;
    if (k >= 30) begin
      n_mismatch++;
      complete_run();
    end
  endtask : wb
  task automatic rdChk(input logic [7:0] a, input int ex, input string nm);
    wb(1'b0, a, 32'h00000000);
    `CHK(nm, ex, rd)
  endtask : rdChk
  task automatic issue(input logic kind, input logic [2:0] src, input int cnt,
                       input logic [5:0] rs, input logic [2:0] em, input int ext);
    hlc_pkg::hlc_loop_req_t r;
    r = {1'b1, kind, src, 12'(cnt), 6'($random(seed)), rs, em, 24'(ext), 24'(body), 24'(cnt)};
    @(posedge clock);
    req <= r;
    waitReady();
    req.valid <= 1'b0;
    waitReady();
  endtask : issue
  task automatic pulse(input logic brk);
    @(posedge clock);
    {loopAbort, loopBreak} <= {!brk, brk};
    @(posedge clock);
    {loopAbort, loopBreak} <= 2'b00;
    waitReady();
    lcM = savedLc.pop_back();
  endtask : pulse
  task automatic fetch(input int cyc);
    @(posedge clock);
    startAddr <= 24'(body);
    run <= 1'b1;
    slow <= 1'($random(seed));
    repeat (cyc) @(posedge clock);
    run <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : fetch
  ////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h445f;
    {srst, wbCyc, wbStb, wbWe, loopAbort, loopBreak, run, slow} = 8'h80;
    {wbSel, wbAdr, wbDatI, startAddr} = '0;
    req = '0;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    `CHK("ready", 1'b1, loopReady)
    for (int a = 0; a < 20; a += 4) rdChk(8'(a), 0, "reset value");
    v = $random(seed) & 32'hFFFFDFFF;
    wb(1'b1, aStat, v);
    v = v & 32'h00FF3FFF;
    rdChk(aStat, v, "status");
    wb(1'b1, aEnd, 32'h00123456);
    wb(1'b1, 8'h10, 32'h00123456);
    rdChk(aEnd, 0, "read-only end");
    rdChk(8'h10, 0, "unmapped");
    body = 'h100 + {$random(seed)} % 256;
    la = body + 1 + {$random(seed)} % 4;
    issue(1'b0, 3'h2, 0, 6'h01, 3'h1, la);
    savedLc.push_back(lcM);
    rdChk(aDep, 2, "depth");
    rdChk(aCnt, lcM, "count");
    rdChk(aEnd, la, "end");
    rdChk(aStat, v | 32'hC000, "status");
    r0 = nRedir;
    fetch(80);
    lcM = (lcM - (nRedir - r0)) & 'hFFFFFF;
    `CHK("body start", body, lastRedir)
    rdChk(aCnt, lcM, "count");
    `CHK("still looping", 1'b1, statusWord[15])
    pulse(1'b0);
    rdChk(aStat, v, "status");
    issue(1'b0, 3'h2, 0, 6'h01, 3'h1, la);
    savedLc.push_back(lcM);
    pulse(1'b1);
    `CHK("break exit", la + 1, lastRedir)
    for (int s = 0; s < 5; s++) begin
      n = 2 + {$random(seed)} % 3;
      la = 3 + {$random(seed)} % 3;
      issue(1'b1, 3'(s), n, 6'h01, 3'h1, la);
      savedLc.push_back(lcM);
      lcM = (s == 4) ? 1 : n;
      rdChk(aCnt, lcM, "count");
      rdChk(aEnd, body + la, "end");
      rdChk(aDep, 2, "depth");
      r0 = nRedir;
      fetch(80);
      `CHK("passes", lcM - 1, nRedir - r0)
      lcM = savedLc.pop_back();
      rdChk(aCnt, lcM, "restored count");
    end
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, aStat, (k == 0) ? 32'h00002000 : 32'h00000000);
      r0 = nRedir;
      issue(1'b1, 3'h2, (k == 1) ? 'hF5C : 0, 6'h01, 3'h1, 4);
      if (k < 2) begin
        savedLc.push_back(lcM);
        rdChk(aCnt, (k == 0) ? 'h10000 : 'hF5C, "count");
        pulse(1'b0);
      end else begin
        `CHK("skip", body + 5, lastRedir)
        `CHK("skip passes", 1, nRedir - r0)
      end
    end
    r0 = nReject;
    issue(1'b1, 3'h3, 3, hlc_pkg::REG_CODE_SSH, 3'h1, 4);
    issue(1'b1, 3'h0, 3, 6'h01, hlc_pkg::EA_MODE_LONG_DISP, 4);
    @(posedge clock);
    `CHK("refused", 2, nReject - r0)
    rdChk(aDep, 0, "depth");
    `CHK("stack error", 0, nErr)
    complete_run();
  end
endmodule : tb
